/* File: core/pdm_top.v */
// Peripheral DMA channel pair: APB registers, channels and transfer engine
`timescale 1ns/100ps
`default_nettype none
`include "pdm_consts.vh"

// Overview of operation
// - Receive pointer addresses next receive write
// - Receive counter holds remaining receive transfers
// - Transmit pointer addresses read, advances per transfer
// - Transmit counter zero stops transmit moves
// - Receive next pointer holds following buffer
// - Receive next counter holds following size
// - Transmit next pointer holds following buffer
// - Transmit next counter holds following size
// - Control bit 0 enables receive unless off
// - Control bit 1 disables receive requests
// - Control bit 8 enables transmit requests
// - Control bit 9 disables transmit requests
// - State bit 0 shows receive enable
// - State bit 8 shows transmit enable
// - Empty counter reloads from next, next cleared
// - Buffer done and all done flags raised
// - Pointer steps 1/2/4, count decrements
// - Counter writes clear that channel's flags
module pdm_top (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Peripheral side
    input  wire        per_rx_ready,
    input  wire [31:0] per_rx_data,
    output reg         per_rx_taken,
    input  wire        per_tx_ready,
    output reg  [31:0] per_tx_data,
    output reg         per_tx_valid,
    // Memory side
    output reg         mem_req,
    output reg         mem_write,
    output reg  [31:0] mem_addr,
    output reg  [1:0]  mem_size,
    output reg  [31:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [31:0] mem_rdata,
    // Interrupt
    output wire        irq
);

    // ============================================================
    // Engine states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RX   = 2'h1;
    localparam [1:0] ST_TX   = 2'h2;
    localparam [1:0] ST_GAP  = 2'h3;

    // ============================================================
    // Declarations
    wire        wr_acc;
    wire        setup;
    wire        wr_rx_ptr;
    wire        wr_rx_cnt;
    wire        wr_rx_nptr;
    wire        wr_rx_ncnt;
    wire        wr_tx_ptr;
    wire        wr_tx_cnt;
    wire        wr_tx_nptr;
    wire        wr_tx_ncnt;
    wire        wr_ctrl;
    wire        wr_clr;
    wire        wr_en;
    wire        wr_size;
    wire [31:0] rx_address;
    wire [15:0] rx_remaining;
    wire [31:0] rx_following_address;
    wire [15:0] rx_following_size;
    wire [31:0] tx_address;
    wire [15:0] tx_remaining;
    wire [31:0] tx_following_address;
    wire [15:0] tx_following_size;
    wire        rx_end;
    wire        rx_all;
    wire        tx_end;
    wire        tx_all;
    wire [3:0]  evt_set;
    wire [3:0]  evt_clr;
    wire [3:0]  evt_stat;
    wire [3:0]  evt_en;
    wire        rx_request_on;
    wire        rx_request_off;
    wire        tx_request_on;
    wire        tx_request_off;
    wire        rx_go;
    wire        tx_go;
    reg         rx_en_reg;
    reg         tx_en_reg;
    reg  [1:0]  rx_size_reg;
    reg  [1:0]  tx_size_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         rx_step_reg;
    reg         tx_step_reg;
    reg  [31:0] rd_mux;
    reg         rd_hit;

    // ============================================================
    // APB decode; a write lands only at the access edge with pready
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pready && pwrite && !pslverr;

    assign wr_rx_ptr  = wr_acc && (paddr == `PDM_OFF_RX_PTR);
    assign wr_rx_cnt  = wr_acc && (paddr == `PDM_OFF_RX_CNT);
    assign wr_tx_ptr  = wr_acc && (paddr == `PDM_OFF_TX_PTR);
    assign wr_tx_cnt  = wr_acc && (paddr == `PDM_OFF_TX_CNT);
    assign wr_rx_nptr = wr_acc && (paddr == `PDM_OFF_RX_NPTR);
    assign wr_rx_ncnt = wr_acc && (paddr == `PDM_OFF_RX_NCNT);
    assign wr_tx_nptr = wr_acc && (paddr == `PDM_OFF_TX_NPTR);
    assign wr_tx_ncnt = wr_acc && (paddr == `PDM_OFF_TX_NCNT);
    assign wr_ctrl    = wr_acc && (paddr == `PDM_OFF_CTRL);
    assign wr_clr     = wr_acc && (paddr == `PDM_OFF_EVT_CLR);
    assign wr_en      = wr_acc && (paddr == `PDM_OFF_EVT_EN);
    assign wr_size    = wr_acc && (paddr == `PDM_OFF_SIZE);

    // ============================================================
    // Read mux; write-only and reserved bits read as zero
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr)
            `PDM_OFF_RX_PTR:   rd_mux = rx_address;
            `PDM_OFF_RX_CNT:   rd_mux = {16'h0000, rx_remaining};
            `PDM_OFF_TX_PTR:   rd_mux = tx_address;
            `PDM_OFF_TX_CNT:   rd_mux = {16'h0000, tx_remaining};
            `PDM_OFF_RX_NPTR:  rd_mux = rx_following_address;
            `PDM_OFF_RX_NCNT:  rd_mux = {16'h0000, rx_following_size};
            `PDM_OFF_TX_NPTR:  rd_mux = tx_following_address;
            `PDM_OFF_TX_NCNT:  rd_mux = {16'h0000, tx_following_size};
            `PDM_OFF_CTRL:     rd_mux = 32'h00000000;
            `PDM_OFF_STATE: begin
                rd_mux[`PDM_RX_ON_BIT] = rx_en_reg;
                rd_mux[`PDM_TX_ON_BIT] = tx_en_reg;
            end
            `PDM_OFF_EVT_STAT: rd_mux = {28'h0000000, evt_stat};
            `PDM_OFF_EVT_CLR:  rd_mux = 32'h00000000;
            `PDM_OFF_EVT_EN:   rd_mux = {28'h0000000, evt_en};
            `PDM_OFF_SIZE: begin
                rd_mux[`PDM_SIZE_RX_LSB+1:`PDM_SIZE_RX_LSB] = rx_size_reg;
                rd_mux[`PDM_SIZE_TX_LSB+1:`PDM_SIZE_TX_LSB] = tx_size_reg;
            end
            default:           rd_hit = 1'b0;
        endcase
    end

    // ============================================================
    // APB answer: one wait-free access phase, data captured at setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pready  <= 1'b1;
            pslverr <= !rd_hit;
        end else begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ============================================================
    // Transfer enable commands
    assign rx_request_on  = pwdata[`PDM_RX_ON_BIT];
    assign rx_request_off = pwdata[`PDM_RX_OFF_BIT];
    assign tx_request_on  = pwdata[`PDM_TX_ON_BIT];
    assign tx_request_off = pwdata[`PDM_TX_OFF_BIT];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en_reg   <= 1'b0;
            tx_en_reg   <= 1'b0;
            rx_size_reg <= `PDM_SIZE_BYTE;
            tx_size_reg <= `PDM_SIZE_BYTE;
        end else begin
            if (wr_ctrl) begin
                if (rx_request_off)
                    rx_en_reg <= 1'b0;
                else if (rx_request_on)
                    rx_en_reg <= 1'b1;
                if (tx_request_off)
                    tx_en_reg <= 1'b0;
                else if (tx_request_on)
                    tx_en_reg <= 1'b1;
            end
            if (wr_size) begin
                rx_size_reg <= pwdata[`PDM_SIZE_RX_LSB+1:`PDM_SIZE_RX_LSB];
                tx_size_reg <= pwdata[`PDM_SIZE_TX_LSB+1:`PDM_SIZE_TX_LSB];
            end
        end
    end

    // ============================================================
    // Channels
    pdm_chan u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_ptr    (wr_rx_ptr),
        .wr_cnt    (wr_rx_cnt),
        .wr_nptr   (wr_rx_nptr),
        .wr_ncnt   (wr_rx_ncnt),
        .wdata     (pwdata),
        .step      (rx_step_reg),
        .step_size (rx_size_reg),
        .ptr_reg   (rx_address),
        .cnt_reg   (rx_remaining),
        .nptr_reg  (rx_following_address),
        .ncnt_reg  (rx_following_size),
        .end_evt   (rx_end),
        .all_evt   (rx_all)
    );

    pdm_chan u_tx (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_ptr    (wr_tx_ptr),
        .wr_cnt    (wr_tx_cnt),
        .wr_nptr   (wr_tx_nptr),
        .wr_ncnt   (wr_tx_ncnt),
        .wdata     (pwdata),
        .step      (tx_step_reg),
        .step_size (tx_size_reg),
        .ptr_reg   (tx_address),
        .cnt_reg   (tx_remaining),
        .nptr_reg  (tx_following_address),
        .ncnt_reg  (tx_following_size),
        .end_evt   (tx_end),
        .all_evt   (tx_all)
    );

    // ============================================================
    // Event flags and interrupt
    assign evt_set = {tx_all, tx_end, rx_all, rx_end};
    assign evt_clr = (wr_clr ? pwdata[3:0] : 4'h0)
                   | {{2{wr_tx_cnt || wr_tx_ncnt}}, {2{wr_rx_cnt || wr_rx_ncnt}}};

    pdm_evt u_evt (
        .pclk     (pclk),
        .presetn  (presetn),
        .set      (evt_set),
        .clr      (evt_clr),
        .wr_en    (wr_en),
        .wdata    (pwdata[3:0]),
        .stat_reg (evt_stat),
        .en_reg   (evt_en),
        .irq_reg  (irq)
    );

    // ============================================================
    // Transfer engine; receive served before transmit
    assign rx_go = rx_en_reg && per_rx_ready && (rx_remaining != 16'h0000);
    assign tx_go = tx_en_reg && per_tx_ready && (tx_remaining != 16'h0000);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (rx_go)
                    state_next = ST_RX;
                else if (tx_go)
                    state_next = ST_TX;
            end
            ST_RX, ST_TX: begin
                if (mem_ack)
                    state_next = ST_GAP;
            end
            // Lets counters settle and the peripheral drop its ready
            ST_GAP:  state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_IDLE;
            mem_req      <= 1'b0;
            mem_write    <= 1'b0;
            mem_addr     <= 32'h00000000;
            mem_size     <= `PDM_SIZE_BYTE;
            mem_wdata    <= 32'h00000000;
            per_rx_taken <= 1'b0;
            per_tx_data  <= 32'h00000000;
            per_tx_valid <= 1'b0;
            rx_step_reg  <= 1'b0;
            tx_step_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            per_rx_taken <= 1'b0;
            per_tx_valid <= 1'b0;
            rx_step_reg  <= 1'b0;
            tx_step_reg  <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (rx_go) begin
                        mem_req   <= 1'b1;
                        mem_write <= 1'b1;
                        mem_addr  <= rx_address;
                        mem_size  <= rx_size_reg;
                        mem_wdata <= per_rx_data;
                    end else if (tx_go) begin
                        mem_req   <= 1'b1;
                        mem_write <= 1'b0;
                        mem_addr  <= tx_address;
                        mem_size  <= tx_size_reg;
                    end
                end
                ST_RX: begin
                    if (mem_ack) begin
                        mem_req      <= 1'b0;
                        per_rx_taken <= 1'b1;
                        rx_step_reg  <= 1'b1;
                    end
                end
                ST_TX: begin
                    if (mem_ack) begin
                        mem_req      <= 1'b0;
                        per_tx_data  <= mem_rdata;
                        per_tx_valid <= 1'b1;
                        tx_step_reg  <= 1'b1;
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: core/pdm_consts.vh */
// Register map, field positions and codes of the peripheral DMA channel pair
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// ==========
// Register byte offsets
`define PDM_OFF_RX_PTR      12'h100
`define PDM_OFF_RX_CNT      12'h104
`define PDM_OFF_TX_PTR      12'h108
`define PDM_OFF_TX_CNT      12'h10C
`define PDM_OFF_RX_NPTR     12'h110
`define PDM_OFF_RX_NCNT     12'h114
`define PDM_OFF_TX_NPTR     12'h118
`define PDM_OFF_TX_NCNT     12'h11C
`define PDM_OFF_CTRL        12'h120
`define PDM_OFF_STATE       12'h124
`define PDM_OFF_EVT_STAT    12'h128
`define PDM_OFF_EVT_CLR     12'h12C
`define PDM_OFF_EVT_EN      12'h130
`define PDM_OFF_SIZE        12'h134

// ==========
// Control and state bit positions
`define PDM_RX_ON_BIT       0
`define PDM_RX_OFF_BIT      1
`define PDM_TX_ON_BIT       8
`define PDM_TX_OFF_BIT      9

// ==========
// Event bit positions
`define PDM_EVT_RX_DONE     0
`define PDM_EVT_RX_ALL      1
`define PDM_EVT_TX_DONE     2
`define PDM_EVT_TX_ALL      3
`define PDM_EVT_W           4

// ==========
// Transfer size field: low bits rx, bits 9:8 tx
`define PDM_SIZE_RX_LSB     0
`define PDM_SIZE_TX_LSB     8
`define PDM_SIZE_BYTE       2'h0
`define PDM_SIZE_HALF       2'h1
`define PDM_SIZE_WORD       2'h2

// ==========
// Reset values
`define PDM_PTR_RST         32'h00000000
`define PDM_CNT_RST         16'h0000

`endif

/* File: core/pdm_chan.v */
// One channel: current and next pointer and counter with buffer chaining
`timescale 1ns/100ps
`default_nettype none
`include "pdm_consts.vh"

module pdm_chan (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Software writes
    input  wire        wr_ptr,
    input  wire        wr_cnt,
    input  wire        wr_nptr,
    input  wire        wr_ncnt,
    input  wire [31:0] wdata,
    // Transfer completion
    input  wire        step,
    input  wire [1:0]  step_size,
    // State
    output reg  [31:0] ptr_reg,
    output reg  [15:0] cnt_reg,
    output reg  [31:0] nptr_reg,
    output reg  [15:0] ncnt_reg,
    output reg         end_evt,
    output reg         all_evt
);

    // ==========
    // Address step
    wire [31:0] incr;
    wire [15:0] cnt_dec;
    wire        reload;

    assign incr    = (step_size == `PDM_SIZE_WORD) ? 32'h00000004 :
                     (step_size == `PDM_SIZE_HALF) ? 32'h00000002 : 32'h00000001;
    assign cnt_dec = cnt_reg - 16'h0001;
    // Chain in when the current buffer is empty, a next one waits and no pointer, count or next count write lands
    assign reload  = (cnt_reg == 16'h0000) && (ncnt_reg != 16'h0000) && !wr_cnt && !wr_ptr && !wr_ncnt;

    // ==========
    // Registers; software writes win over a completing transfer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg  <= `PDM_PTR_RST;
            cnt_reg  <= `PDM_CNT_RST;
            nptr_reg <= `PDM_PTR_RST;
            ncnt_reg <= `PDM_CNT_RST;
            end_evt  <= 1'b0;
            all_evt  <= 1'b0;
        end else begin
            end_evt <= 1'b0;
            all_evt <= 1'b0;
            if (wr_nptr)
                nptr_reg <= wdata;
            if (wr_ncnt)
                ncnt_reg <= wdata[15:0];
            if (wr_ptr)
                ptr_reg <= wdata;
            else if (reload)
                ptr_reg <= nptr_reg;
            else if (step)
                ptr_reg <= ptr_reg + incr;
            if (wr_cnt)
                cnt_reg <= wdata[15:0];
            else if (reload) begin
                cnt_reg  <= ncnt_reg;
                ncnt_reg <= 16'h0000;
            end else if (step && cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_dec;
                if (cnt_dec == 16'h0000) begin
                    end_evt <= 1'b1;
                    all_evt <= (ncnt_reg == 16'h0000) && !wr_ncnt;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: core/pdm_evt.v */
// Sticky event flags with enable mask and one level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "pdm_consts.vh"

module pdm_evt (
    // Clock and reset
    input  wire                     pclk,
    input  wire                     presetn,
    // Events and clears
    input  wire [`PDM_EVT_W-1:0]    set,
    input  wire [`PDM_EVT_W-1:0]    clr,
    input  wire                     wr_en,
    input  wire [`PDM_EVT_W-1:0]    wdata,
    // State
    output reg  [`PDM_EVT_W-1:0]    stat_reg,
    output reg  [`PDM_EVT_W-1:0]    en_reg,
    output reg                      irq_reg
);

    // ==========
    // Set wins over a clear in the same cycle so no event is lost
    wire [`PDM_EVT_W-1:0] stat_next;

    assign stat_next = (stat_reg & ~clr) | set;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= {`PDM_EVT_W{1'b0}};
            en_reg   <= {`PDM_EVT_W{1'b0}};
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (wr_en)
                en_reg <= wdata;
            irq_reg <= |(stat_next & (wr_en ? wdata : en_reg));
        end
    end

endmodule
`default_nettype wire

/* File: test/pdm_chk.sv */
// Checker of bus and transfer handshakes
`timescale 1ns/100ps
`default_nettype none
module pdm_chk (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Transfers
    input wire logic        per_rx_taken,
    input wire logic        per_tx_valid,
    input wire logic [31:0] per_tx_data,
    input wire logic        mem_req,
    input wire logic        mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Steps
    sequence s_setup; psel && !penable; endsequence
    sequence s_unmap; psel && !penable && (paddr < 12'h100 || paddr > 12'h134); endsequence
    sequence s_done; mem_req && mem_ack; endsequence
    // ==========
    // Properties
    a_ready_first: assert property (s_setup |=> pready && penable)
        else $error("no ready in access");
    a_error_unmap: assert property (s_unmap |=> pslverr)
        else $error("unmapped not refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_hold_req: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request dropped early");
    a_rx_taken: assert property (s_done ##0 mem_write |=> per_rx_taken && !mem_req)
        else $error("receive store not signalled");
    a_tx_data: assert property (s_done ##0 !mem_write |=> per_tx_valid && per_tx_data == $past(mem_rdata))
        else $error("transmit data wrong");
    a_req_gap: assert property (s_done |=> !mem_req [*2])
        else $error("request too soon");
    a_pulse_one: assert property (per_rx_taken || per_tx_valid |=> !per_rx_taken && !per_tx_valid)
        else $error("pulse too long");
endmodule
bind pdm_top pdm_chk pdm_chk_i (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .per_rx_taken, .per_tx_valid, .per_tx_data, .mem_req, .mem_write, .mem_addr, .mem_rdata, .mem_ack);
`default_nettype wire

/* File: test/pdm_partner.sv */
// Peripheral and memory model at the far side
`timescale 1ns/100ps
`default_nettype none
module pdm_partner (
    // Clock, reset and steering
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        slow,
    input wire logic        rx_go,
    input wire logic [31:0] rx_word,
    // Peripheral
    input wire logic        per_rx_taken,
    input wire logic        per_tx_valid,
    output var logic        per_rx_ready,
    output var logic [31:0] per_rx_data,
    output var logic        per_tx_ready,
    // Memory
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    output var logic        mem_ack,
    output var logic [31:0] mem_rdata
);
    logic [1:0] w;
    // Idle buses keep changing so stale values never match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mem_ack, per_rx_ready, per_tx_ready, w} <= 5'h0;
            mem_rdata <= 32'h0;
            per_rx_data <= 32'h0;
        end else begin
            mem_ack <= 1'h0;
            mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]};
            if (mem_req && !mem_ack) begin
                w <= w + 2'h1;
                if (w == (slow ? 2'h3 : 2'h0)) begin
                    mem_ack <= 1'h1;
                    mem_rdata <= mem_addr ^ 32'h5A5A0000;
                    w <= 2'h0;
                end
            end
            per_rx_ready <= rx_go && !per_rx_taken;
            if (!(rx_go && !per_rx_taken))
                per_rx_data <= ~per_rx_data;
            else if (!per_rx_ready)
                per_rx_data <= rx_word;
            per_tx_ready <= !per_tx_valid;
        end
    end
endmodule
`default_nettype wire

/* File: test/pdm_top_bench.sv */
// Self-checking bench of the DMA channel pair
`timescale 1ns/100ps
`default_nettype none
module pdm_top_bench;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        slow = 1'h0, rx_go = 1'h0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rx_word = 32'h0, rd, exp_tx, seed = 32'hF777610A;
    wire  [31:0] prdata, per_rx_data, per_tx_data, mem_addr, mem_wdata, mem_rdata;
    wire  [1:0]  mem_size;
    wire         pready, pslverr, per_rx_ready, per_rx_taken, per_tx_ready, per_tx_valid;
    wire         mem_req, mem_write, mem_ack, irq;
    int          error_cnt, n_compared, n_xfer, k, mc, m_st, m_evt, m_en;
    int          m_ptr[2], m_cnt[2], m_nptr[2], m_ncnt[2], m_sz[2];
    int          ctl[8] = '{32'h1, 32'h0, 32'h3, 32'h100, 32'h300, 32'h101, 32'h2, 32'h200};
    always #2.5 pclk = ~pclk;
    pdm_top pdm_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .per_rx_ready, .per_rx_data, .per_rx_taken, .per_tx_ready, .per_tx_data, .per_tx_valid,
        .mem_req, .mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .irq);
    pdm_partner pdm_partner_i (.pclk, .presetn, .slow, .rx_go, .rx_word, .per_rx_taken, .per_tx_valid,
        .per_rx_ready, .per_rx_data, .per_tx_ready, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    // ==========
    // Helpers
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] s, e, input string m);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Next buffer takes over when current empties
    task automatic chain(input int c);
        if (m_cnt[c] == 0 && m_ncnt[c] != 0) begin
            m_ptr[c] = m_nptr[c];
            m_cnt[c] = m_ncnt[c];
            m_ncnt[c] = 0;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'h1 && k < 20);
        if (k >= 20) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        int c;
        apb(1'h1, a, d);
        c = a[3];
        case (a)
            12'h100, 12'h108: m_ptr[c] = d;
            12'h110, 12'h118: m_nptr[c] = d;
            12'h104, 12'h10C: begin m_cnt[c] = d[15:0]; m_evt &= ~(3 << 2*c); end
            12'h114, 12'h11C: begin m_ncnt[c] = d[15:0]; m_evt &= ~(3 << 2*c); end
            12'h120: begin
                m_st = d[1] ? m_st & ~1 : (d[0] ? m_st | 1 : m_st);
                m_st = d[9] ? m_st & ~256 : (d[8] ? m_st | 256 : m_st);
            end
            12'h12C: m_evt &= ~d;
            12'h130: m_en = d & 15;
            12'h134: begin m_sz[0] = d[1:0]; m_sz[1] = d[9:8]; end
        endcase
        chain(c);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'h0, a, 32'h0);
        check(rd, e, m);
    endtask
    // Counters settle three cycles after the ack
    task wait_x(input int n);
        k = 0;
        while (n_xfer < n && k < 300) begin @(posedge pclk); k++; end
        repeat (8) @(posedge pclk);
        check(n_xfer, n, "transfer count");
    endtask
    // ==========
    // Reference model of each finished transfer
    always @(posedge pclk) begin
        if (per_tx_valid === 1'h1) check(per_tx_data, exp_tx, "tx data");
        if (per_rx_taken === 1'h1) rx_word <= xs();
        if (mem_req === 1'h1 && mem_ack === 1'h1) begin
            mc = mem_write ? 0 : 1;
            check(mem_addr, m_ptr[mc], "address");
            check(mem_size, m_sz[mc], "size");
            if (mem_write) check(mem_wdata, rx_word, "rx data");
            exp_tx = mem_addr ^ 32'h5A5A0000;
            m_ptr[mc] += 1 << m_sz[mc];
            m_cnt[mc]--;
            n_xfer++;
            if (m_cnt[mc] == 0) m_evt |= (m_ncnt[mc] == 0 ? 3 : 1) << 2*mc;
            chain(mc);
        end
    end
    // ==========
    // Watchdog, over fifty times the expected run
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 12'h100; a <= 12'h124; a += 4) rdc(a, 0, "reset value");
        apb(1'h0, 12'h200, 32'h0);
        check(err, 1'h1, "unmapped");
        foreach (ctl[i]) begin
            wr(12'h120, ctl[i]);
            rdc(12'h124, m_st, "enable state");
        end
        $display("test reset and enables done");
        slow <= 1'h1;
        wr(12'h134, 32'h1);
        wr(12'h100, xs());
        wr(12'h110, xs());
        wr(12'h104, 32'h2);
        wr(12'h114, 32'h1);
        rx_go <= 1'h1;
        repeat (10) @(posedge pclk);
        check(n_xfer, 0, "disabled receive");
        wr(12'h120, 32'h1);
        wait_x(3);
        rdc(12'h100, m_ptr[0], "rx pointer");
        rdc(12'h104, m_cnt[0], "rx count");
        rdc(12'h114, m_ncnt[0], "rx next count");
        rdc(12'h128, m_evt, "rx flags");
        $display("test receive chain done");
        slow <= 1'h0;
        wr(12'h120, 32'h100);
        for (int s = 0; s < 3; s++) begin
            wr(12'h134, s << 8);
            wr(12'h108, xs());
            wr(12'h10C, 32'h1);
            wait_x(4 + s);
            rdc(12'h108, m_ptr[1], "tx pointer");
        end
        wr(12'h118, xs());
        wr(12'h11C, 32'h2);
        wait_x(8);
        rdc(12'h108, m_ptr[1], "tx chained pointer");
        rdc(12'h10C, m_cnt[1], "tx count");
        rdc(12'h128, m_evt, "tx flags");
        $display("test transmit done");
        wr(12'h130, 32'h2);
        rdc(12'h130, m_en, "enable mask");
        check(irq, (m_evt & m_en) != 0, "irq raised");
        wr(12'h130, 32'h0);
        rdc(12'h128, m_evt, "masked flags");
        check(irq, 1'h0, "irq masked");
        wr(12'h130, 32'h3);
        wr(12'h12C, 32'h2);
        rdc(12'h128, m_evt, "cleared flag");
        check(irq, (m_evt & m_en) != 0, "irq kept");
        wr(12'h104, 32'h0);
        rdc(12'h128, m_evt, "count write clears");
        check(irq, (m_evt & m_en) != 0, "irq dropped");
        $display("test interrupt done");
        give_verdict();
    end
endmodule
`default_nettype wire
